// ==== hw/mps_chan_map.sv ====
// Channel range check and four-wire partner relay for the configurable mux.
// Assumes func holds one of the four function codes.
`timescale 1ns/10ps
module mps_chan_map (
   input  wire logic [mps_pkg::FUNC_W-1:0] func,
   input  wire logic [mps_pkg::CHAN_W-1:0] chan,
   output logic                            ok,
   output logic                            tree,
   output logic                            chan2_en,
   output logic [mps_pkg::CHAN_W-1:0]      chan2
);
   import mps_pkg::*;
   wire logic [CHAN_W-1:0] lim;

   // Dual mode keeps the 40 channel range; its halves are 00-19 and 20-39
   assign lim = (func == FUNC_1W) ? CH_1W_LIM :   // RQ8
                (func == FUNC_4W) ? CH_4W_LIM :   // RQ12
                CH_2W_LIM;                        // RQ10 RQ11
   assign tree     = (chan == TREE_LO) || (chan == TREE_HI);
   assign ok       = (chan < lim) || tree;
   assign chan2_en = (func == FUNC_4W) && (chan < CH_4W_LIM);   // RQ12
   assign chan2    = chan + FOUR_WIRE_OFS;                      // RQ12
endmodule

// ==== hw/mps_cmd_top.sv ====
// Command interpreter: card pairing, mux function, breadboard access, scan list.
// Assumes slot kinds and handshake modes are steady while a command runs.
// Functional notes
// RQ1: Paired command runs on both, lower slot first
// RQ2: Pair only two identical modules
// RQ3: Minus one dissolves pair; reset leaves none
// RQ4: Pair query gives four slots, zeros unused
// RQ5: Digital pairs need mode 1 or 2; mirror writes
// RQ6: Mux pairs need same function; mirror changes
// RQ7: Reset to two-wire; function change opens all
// RQ8: Code 1: eighty single-ended channels
// RQ9: Single-ended mode closes one channel at most
// RQ10: Code 2: forty two-wire channels
// RQ11: Code 3: two twenty-channel two-wire muxes
// RQ12: Code 4: channel n drives n+20 too
// RQ13: Function query returns code; empty slot errors
// RQ14: Read register 4 gives inputs; else 255
// RQ15: Write register 0 loads outputs; else ignored
// RQ16: Bit one is line high
// RQ17: Breadboard commands to newer modules error
// RQ18: Scan list holds 200 entries at most
// RQ19: Digital entries need mode 1 or 2; 91-94 allowed
// RQ20: Tree relays 98 and 99 refused
// RQ21: Clear empties list, nothing else changes
// RQ22: Size gives count; entries read in order
// RQ23: Bad slot errors, state unchanged
`timescale 1ns/10ps
module mps_cmd_top #(
   parameter int unsigned MAX_SLOT   = mps_pkg::MAX_SLOT_DEF,
   parameter int unsigned SCAN_DEPTH = mps_pkg::SCAN_DEPTH_DEF
)(
   input  wire logic                                      clock,
   input  wire logic                                      sys_rst,
   input  wire logic                                      cmd_valid,
   output logic                                           cmd_ready,
   input  wire mps_pkg::mps_cmd_t                         cmd_code,
   input  wire logic [mps_pkg::SLOT_W-1:0]                cmd_slot,
   input  wire logic [mps_pkg::DATA_W-1:0]                cmd_arg,
   input  wire logic                                      cmd_arg_neg,
   input  wire logic                                      cmd_setup,
   input  wire logic [mps_pkg::DATA_W-1:0]                cmd_data,
   input  wire logic [MAX_SLOT:0][mps_pkg::KIND_W-1:0]    slot_kind,
   input  wire logic [MAX_SLOT:0][mps_pkg::MODE_W-1:0]    dio_mode,
   input  wire logic [mps_pkg::DATA_W-1:0]                card_rdata,
   output logic                                           card_op_valid,
   output mps_pkg::mps_cmd_t                              card_op_code,
   output logic [mps_pkg::SLOT_W-1:0]                     card_op_slot,
   output logic [mps_pkg::CHAN_W-1:0]                     card_op_chan,
   output logic                                           card_op_chan2_en,
   output logic [mps_pkg::CHAN_W-1:0]                     card_op_chan2,
   output logic [mps_pkg::DATA_W-1:0]                     card_op_data,
   output logic                                           rsp_valid,
   output logic                                           rsp_err,
   output logic [mps_pkg::RSP_W-1:0]                      rsp_data
);
   import mps_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_OP1  = 4'b0010,
      ST_OP2  = 4'b0100,
      ST_MEM  = 4'b1000
   } mps_state_t;

   mps_state_t                       state_q, state_d;
   logic [1:0][SLOT_W-1:0]           pair_lo_q, pair_hi_q;
   logic [MAX_SLOT:0][FUNC_W-1:0]    func_q;
   logic [MAX_SLOT:0]                cl_v_q;
   logic [MAX_SLOT:0][CHAN_W-1:0]    cl_ch_q;
   logic [CNT_W-1:0]                 scan_cnt_q;
   logic [SLOT_W-1:0]                second_q;
   logic                             mirror_q;
   logic                             bb_rd_q;
   mps_mem_if                        mem_if ();

   function automatic logic [SLOT_W-1:0] partner_of(input logic [SLOT_W-1:0] s,
         input logic [1:0][SLOT_W-1:0] lo, input logic [1:0][SLOT_W-1:0] hi);
      partner_of = '0;
      for (int j = 0; j < 2; j++) begin
         if (lo[j] != '0 && lo[j] == s) partner_of = hi[j];
         if (hi[j] != '0 && hi[j] == s) partner_of = lo[j];
      end
   endfunction

   function automatic logic hs_ok(input logic [MODE_W-1:0] m);
      hs_ok = (m == MODE_HS1) || (m == MODE_HS2);
   endfunction

   // Slot decode; indexes are clamped so a bad slot never reads outside the arrays
   wire logic               take   = cmd_valid && cmd_ready;
   wire logic               s0_ok  = cmd_slot <= MAX_SLOT;
   wire logic               s1_ok  = s0_ok && (cmd_slot != '0);   // RQ23
   wire logic [SLOT_W-1:0]  sidx   = s0_ok ? cmd_slot : '0;
   wire logic [SLOT_W-1:0]  s2     = cmd_arg[SLOT_W-1:0];
   wire logic               s2_ok  = (cmd_arg[DATA_W-1:SLOT_W] == '0) && (s2 != '0)
                                     && (s2 <= MAX_SLOT);
   wire logic [SLOT_W-1:0]  s2idx  = s2_ok ? s2 : '0;
   wire logic [KIND_W-1:0]  kind1  = slot_kind[sidx];
   wire logic [KIND_W-1:0]  kind2  = slot_kind[s2idx];
   wire logic [FUNC_W-1:0]  func1  = func_q[sidx];
   wire logic [CHAN_W-1:0]  chan   = cmd_arg[CHAN_W-1:0];
   wire logic [SLOT_W-1:0]  partner  = partner_of(sidx, pair_lo_q, pair_hi_q);
   wire logic [SLOT_W-1:0]  partner2 = partner_of(s2idx, pair_lo_q, pair_hi_q);
   wire logic               hit0   = pair_lo_q[0] == sidx || pair_hi_q[0] == sidx;
   wire logic               free0  = pair_lo_q[0] == '0;
   wire logic               free1  = pair_lo_q[1] == '0;
   wire logic               map_ok, map_tree, map_c2_en;
   wire logic [CHAN_W-1:0]  map_c2;

   mps_chan_map u_map (
      .func     (func1),
      .chan     (chan),
      .ok       (map_ok),
      .tree     (map_tree),
      .chan2_en (map_c2_en),
      .chan2    (map_c2)
   );

   wire logic pair_ok = s1_ok && s2_ok && (s2 != cmd_slot) && (partner == '0)    // RQ2
      && (partner2 == '0) && (free0 || free1) && (kind1 != KIND_EMPTY)
      && (kind1 == kind2)                                                       // RQ2
      && (kind1 != KIND_CFGMUX || func1 == func_q[s2idx])                       // RQ6
      && (kind1 != KIND_DIO || (hs_ok(dio_mode[sidx]) && hs_ok(dio_mode[s2idx]))); // RQ5
   wire logic mux_ok   = s1_ok && kind1 == KIND_CFGMUX;                  // RQ13
   wire logic fcode_ok = cmd_arg >= 8'h01 && cmd_arg <= 8'h04;
   wire logic sw_ok    = s1_ok && (kind1 == KIND_SWITCH || (kind1 == KIND_CFGMUX && map_ok));
   wire logic one_w_blk = kind1 == KIND_CFGMUX && func1 == FUNC_1W            // RQ9
      && cl_v_q[sidx] && cl_ch_q[sidx] != chan;
   wire logic bb_ok    = s1_ok && kind1 == KIND_BBOARD;                  // RQ17
   wire logic bb_w_hit = cmd_arg == BB_OUT_REG;                          // RQ15
   wire logic bb_r_hit = cmd_arg == BB_IN_REG;                           // RQ14
   wire logic builtin  = chan >= BUILTIN_LO && chan <= BUILTIN_HI;
   wire logic entry_ok = cmd_setup                                       // RQ18
      || (cmd_slot == '0 && builtin)                                     // RQ19
      || (cmd_slot != '0 && kind1 == KIND_SWITCH)
      || (cmd_slot != '0 && kind1 == KIND_CFGMUX && map_ok && !map_tree) // RQ20
      || (cmd_slot != '0 && kind1 == KIND_DIO && hs_ok(dio_mode[sidx])); // RQ19
   wire logic scan_ok  = s0_ok && scan_cnt_q < SCAN_DEPTH && entry_ok;   // RQ18 RQ23

   wire logic cmd_ok =
      (cmd_code == CMD_PAIR)       ? (cmd_arg_neg ? s1_ok : pair_ok) :   // RQ3
      (cmd_code == CMD_PAIR_Q)     ? 1'b1 :
      (cmd_code == CMD_FUNC)       ? (mux_ok && fcode_ok) :
      (cmd_code == CMD_FUNC_Q)     ? mux_ok :                            // RQ13
      (cmd_code == CMD_BB_READ)    ? bb_ok :
      (cmd_code == CMD_BB_WRITE)   ? bb_ok :
      (cmd_code == CMD_CLOSE)      ? (sw_ok && !one_w_blk) :             // RQ9
      (cmd_code == CMD_OPEN)       ? sw_ok :
      (cmd_code == CMD_DIO_WRITE)  ? (s1_ok && kind1 == KIND_DIO) :
      (cmd_code == CMD_SCAN_ADD)   ? scan_ok :
      (cmd_code == CMD_SCAN_READ)  ? (cmd_arg < scan_cnt_q) :
      (cmd_code == CMD_SCAN_CLEAR) || (cmd_code == CMD_SCAN_SIZE);

   wire logic needs_op = cmd_ok && ((cmd_code == CMD_FUNC) || (cmd_code == CMD_CLOSE)
      || (cmd_code == CMD_OPEN) || (cmd_code == CMD_DIO_WRITE)
      || (cmd_code == CMD_BB_WRITE && bb_w_hit) || (cmd_code == CMD_BB_READ && bb_r_hit));
   // A read is taken from the addressed card only; every other card op is mirrored
   wire logic               mirror  = partner != '0 && cmd_code != CMD_BB_READ;  // RQ1 RQ5
   wire logic               p_first = mirror && partner < cmd_slot;             // RQ1
   wire logic [SLOT_W-1:0]  lo_slot = p_first ? partner : cmd_slot;
   wire logic [SLOT_W-1:0]  hi_slot = p_first ? cmd_slot : partner;
   wire logic [SLOT_W-1:0]  new_lo  = (s2 < cmd_slot) ? s2 : cmd_slot;
   wire logic [SLOT_W-1:0]  new_hi  = (s2 < cmd_slot) ? cmd_slot : s2;
   wire logic [RSP_W-1:0]   q_data  =
      (cmd_code == CMD_PAIR_Q)    ? {pair_lo_q[0], pair_hi_q[0], pair_lo_q[1], pair_hi_q[1]} :
      (cmd_code == CMD_FUNC_Q)    ? {13'h0000, func1} :                   // RQ13
      (cmd_code == CMD_BB_READ)   ? {8'h00, BB_MISS} :                    // RQ14
      (cmd_code == CMD_SCAN_SIZE) ? {8'h00, scan_cnt_q} :                 // RQ22
      16'h0000;

   assign cmd_ready = state_q == ST_IDLE;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (take && needs_op) state_d = ST_OP1;
            else if (take && cmd_ok && cmd_code == CMD_SCAN_READ) state_d = ST_MEM;
         end
         ST_OP1:  state_d = mirror_q ? ST_OP2 : ST_IDLE;
         ST_OP2:  state_d = ST_IDLE;
         ST_MEM:  state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) state_q <= ST_IDLE;
      else state_q <= state_d;
   end

   // Card operations: first slot on the taking edge, partner one cycle later
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         card_op_valid    <= 1'b0;
         card_op_code     <= CMD_PAIR;
         card_op_slot     <= '0;
         card_op_chan     <= '0;
         card_op_chan2_en <= 1'b0;
         card_op_chan2    <= '0;
         card_op_data     <= '0;
         second_q         <= '0;
         mirror_q         <= 1'b0;
         bb_rd_q          <= 1'b0;
      end else begin
         card_op_valid <= 1'b0;
         if (state_q == ST_IDLE && take && needs_op) begin
            card_op_valid    <= 1'b1;
            card_op_code     <= cmd_code;
            card_op_slot     <= lo_slot;                                 // RQ1
            card_op_chan     <= chan;
            card_op_chan2_en <= map_c2_en && kind1 == KIND_CFGMUX;       // RQ10 RQ12
            card_op_chan2    <= map_c2;
            card_op_data     <= cmd_data;                                // RQ16
            second_q         <= hi_slot;
            mirror_q         <= mirror;
            bb_rd_q          <= cmd_code == CMD_BB_READ;
         end else if (state_q == ST_OP1 && mirror_q) begin
            card_op_valid <= 1'b1;
            card_op_slot  <= second_q;                                   // RQ1 RQ5 RQ6
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_err   <= 1'b0;
         rsp_data  <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (state_q == ST_IDLE && take && !needs_op
               && !(cmd_ok && cmd_code == CMD_SCAN_READ)) begin
            rsp_valid <= 1'b1;
            rsp_err   <= !cmd_ok;                                        // RQ23
            rsp_data  <= cmd_ok ? q_data : '0;                           // RQ4
         end else if (state_d == ST_IDLE && state_q != ST_IDLE) begin
            rsp_valid <= 1'b1;
            rsp_err   <= 1'b0;
            if (state_q == ST_MEM) rsp_data <= {4'h0, mem_if.rdata};     // RQ22
            else if (state_q == ST_OP1 && bb_rd_q) rsp_data <= {8'h00, card_rdata}; // RQ14
            else rsp_data <= '0;
         end else if (state_q == ST_OP1 && bb_rd_q) begin
            rsp_data <= {8'h00, card_rdata};
         end
      end
   end

   // Pair table; a dissolved first pair is refilled from the second
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pair_lo_q <= '0;                                                // RQ3
         pair_hi_q <= '0;
      end else if (take && cmd_code == CMD_PAIR && cmd_ok) begin
         if (cmd_arg_neg && partner != '0) begin                         // RQ3
            pair_lo_q[1] <= '0;
            pair_hi_q[1] <= '0;
            if (hit0) begin                                              // RQ4
               pair_lo_q[0] <= pair_lo_q[1];
               pair_hi_q[0] <= pair_hi_q[1];
            end
         end else if (!cmd_arg_neg && free0) begin
            pair_lo_q[0] <= new_lo;
            pair_hi_q[0] <= new_hi;
         end else if (!cmd_arg_neg) begin
            pair_lo_q[1] <= new_lo;
            pair_hi_q[1] <= new_hi;
         end
      end
   end

   // Per-slot function and single-ended closed channel tracking
   for (genvar i = 0; i <= MAX_SLOT; i++) begin : g_slot
      wire logic hit = take && cmd_ok && s0_ok
         && (sidx == i[SLOT_W-1:0] || (partner != '0 && partner == i[SLOT_W-1:0]));
      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            func_q[i]  <= FUNC_RESET;                                    // RQ7
            cl_v_q[i]  <= 1'b0;
            cl_ch_q[i] <= '0;
         end else if (hit && cmd_code == CMD_FUNC) begin
            func_q[i]  <= cmd_arg[FUNC_W-1:0];                           // RQ6 RQ7
            cl_v_q[i]  <= 1'b0;                                          // RQ7
         end else if (hit && cmd_code == CMD_CLOSE && func_q[i] == FUNC_1W) begin
            cl_v_q[i]  <= 1'b1;                                          // RQ9
            cl_ch_q[i] <= chan;
         end else if (hit && cmd_code == CMD_OPEN && cl_ch_q[i] == chan) begin
            cl_v_q[i]  <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) scan_cnt_q <= '0;
      else if (take && cmd_code == CMD_SCAN_CLEAR) scan_cnt_q <= '0;    // RQ21
      else if (mem_if.wr_en) scan_cnt_q <= scan_cnt_q + 8'h01;          // RQ18
   end

   assign mem_if.wr_en = take && cmd_code == CMD_SCAN_ADD && cmd_ok;
   assign mem_if.waddr = scan_cnt_q;                                     // RQ22
   assign mem_if.wdata = {cmd_setup, cmd_slot, chan};
   assign mem_if.raddr = cmd_arg;

   mps_scan_mem #(.DEPTH(SCAN_DEPTH)) u_mem (
      .clock   (clock),
      .port_if (mem_if.mem)
   );

   sequence s_first_op;
      card_op_valid && state_q == ST_OP1 && mirror_q;
   endsequence
   sequence s_second_op;
      card_op_valid && state_q == ST_OP2 && card_op_slot > $past(card_op_slot);
   endsequence

   a_pair_low_first: assert property (@(posedge clock) disable iff (sys_rst) // RQ1
      s_first_op |=> s_second_op ##1 rsp_valid) else $error("mirror order wrong");
   a_pair_two_same: assert property (@(posedge clock) disable iff (sys_rst) // RQ2
      pair_lo_q[0] != '0 |-> pair_lo_q[0] < pair_hi_q[0]
      && slot_kind[pair_lo_q[0]] == slot_kind[pair_hi_q[0]]) else $error("bad pair");
   a_unpair_clears: assert property (@(posedge clock) disable iff (sys_rst) // RQ3
      take && cmd_code == CMD_PAIR && cmd_arg_neg && s1_ok
      |=> partner_of($past(sidx), pair_lo_q, pair_hi_q) == '0) else $error("pair kept");
   a_func_opens_all: assert property (@(posedge clock) disable iff (sys_rst) // RQ7
      take && cmd_code == CMD_FUNC && cmd_ok
      |=> card_op_valid && card_op_code == CMD_FUNC && !cl_v_q[$past(sidx)])
      else $error("function op missing");
   a_one_closed: assert property (@(posedge clock) disable iff (sys_rst) // RQ9
      take && cmd_code == CMD_CLOSE && one_w_blk |=> rsp_valid && rsp_err
      && !card_op_valid) else $error("second close allowed");
   a_four_wire_pair: assert property (@(posedge clock) disable iff (sys_rst) // RQ12
      card_op_valid && card_op_chan2_en |-> card_op_chan2 == card_op_chan + 7'h14)
      else $error("four wire partner wrong");
   a_bb_miss_value: assert property (@(posedge clock) disable iff (sys_rst) // RQ14
      take && cmd_code == CMD_BB_READ && bb_ok && !bb_r_hit
      |=> rsp_valid && !rsp_err && rsp_data == 16'h00ff) else $error("miss not 255");
   a_scan_bound: assert property (@(posedge clock) disable iff (sys_rst) // RQ18
      scan_cnt_q <= SCAN_DEPTH and (mem_if.wr_en |-> scan_cnt_q < SCAN_DEPTH))
      else $error("scan list overflow");
   a_scan_clear: assert property (@(posedge clock) disable iff (sys_rst) // RQ21
      take && cmd_code == CMD_SCAN_CLEAR |=> scan_cnt_q == '0 && $stable(pair_lo_q)
      && $stable(func_q)) else $error("clear incomplete");
   a_bad_slot: assert property (@(posedge clock) disable iff (sys_rst) // RQ23
      take && !s0_ok && cmd_code != CMD_PAIR_Q && cmd_code != CMD_SCAN_SIZE
      && cmd_code != CMD_SCAN_CLEAR && cmd_code != CMD_SCAN_READ
      |=> rsp_valid && rsp_err && $stable(pair_lo_q) && $stable(scan_cnt_q))
      else $error("bad slot accepted");
endmodule

// ==== hw/mps_scan_mem.sv ====
// Scan list store: one entry per word, read data from a register.
// Assumes the writer never addresses beyond DEPTH.
`timescale 1ns/10ps
module mps_scan_mem #(
   parameter int unsigned DEPTH = mps_pkg::SCAN_DEPTH_DEF
)(
   input wire logic clock,
   mps_mem_if.mem   port_if
);
   import mps_pkg::*;
   logic [ENTRY_W-1:0] store [DEPTH];

   // No reset: the entry count alone says what is valid
   always_ff @(posedge clock) begin
      if (port_if.wr_en) begin
         store[port_if.waddr] <= port_if.wdata;
      end
      port_if.rdata <= store[port_if.raddr];
   end
endmodule

// ==== pkg/mps_mem_if.sv ====
// Port bundle between the command logic and the scan list store.
// Assumes the store samples on the system clock and registers its read data.
`timescale 1ns/10ps
interface mps_mem_if;
   import mps_pkg::*;
   logic               wr_en;
   logic [CNT_W-1:0]   waddr;
   logic [ENTRY_W-1:0] wdata;
   logic [CNT_W-1:0]   raddr;
   logic [ENTRY_W-1:0] rdata;
   modport ctrl (output wr_en, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input wr_en, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== pkg/mps_pkg.sv ====
// Shared constants and types for the card pairing and scan list block.
// Assumes one system clock; slot kinds and handshake modes come from the slots.
package mps_pkg;
   localparam int unsigned SLOT_W         = 4;
   localparam int unsigned CHAN_W         = 7;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned KIND_W         = 3;
   localparam int unsigned MODE_W         = 3;
   localparam int unsigned FUNC_W         = 3;
   localparam int unsigned CNT_W          = 8;
   localparam int unsigned ENTRY_W        = 1 + SLOT_W + CHAN_W;
   localparam int unsigned RSP_W          = 16;
   localparam int unsigned MAX_SLOT_DEF   = 9;
   localparam int unsigned SCAN_DEPTH_DEF = 200;

   typedef enum logic [3:0] {
      CMD_PAIR       = 4'h1,
      CMD_PAIR_Q     = 4'h2,
      CMD_FUNC       = 4'h3,
      CMD_FUNC_Q     = 4'h4,
      CMD_BB_READ    = 4'h5,
      CMD_BB_WRITE   = 4'h6,
      CMD_CLOSE      = 4'h7,
      CMD_OPEN       = 4'h8,
      CMD_DIO_WRITE  = 4'h9,
      CMD_SCAN_ADD   = 4'ha,
      CMD_SCAN_CLEAR = 4'hb,
      CMD_SCAN_SIZE  = 4'hc,
      CMD_SCAN_READ  = 4'hd
   } mps_cmd_t;

   localparam logic [KIND_W-1:0] KIND_EMPTY  = 3'h0;
   localparam logic [KIND_W-1:0] KIND_SWITCH = 3'h1;
   localparam logic [KIND_W-1:0] KIND_CFGMUX = 3'h2;
   localparam logic [KIND_W-1:0] KIND_DIO    = 3'h3;
   localparam logic [KIND_W-1:0] KIND_BBOARD = 3'h4;
   localparam logic [KIND_W-1:0] KIND_NEWER  = 3'h5;

   localparam logic [MODE_W-1:0] MODE_HS1 = 3'h1;
   localparam logic [MODE_W-1:0] MODE_HS2 = 3'h2;

   localparam logic [FUNC_W-1:0] FUNC_1W    = 3'h1;
   localparam logic [FUNC_W-1:0] FUNC_2W    = 3'h2;
   localparam logic [FUNC_W-1:0] FUNC_DUAL  = 3'h3;
   localparam logic [FUNC_W-1:0] FUNC_4W    = 3'h4;
   localparam logic [FUNC_W-1:0] FUNC_RESET = FUNC_2W;

   localparam logic [DATA_W-1:0] BB_OUT_REG = 8'h00;
   localparam logic [DATA_W-1:0] BB_IN_REG  = 8'h04;
   localparam logic [DATA_W-1:0] BB_MISS    = 8'hff;

   localparam logic [CHAN_W-1:0] CH_1W_LIM     = 7'h50;
   localparam logic [CHAN_W-1:0] CH_2W_LIM     = 7'h28;
   localparam logic [CHAN_W-1:0] CH_4W_LIM     = 7'h14;
   localparam logic [CHAN_W-1:0] FOUR_WIRE_OFS = 7'h14;
   localparam logic [CHAN_W-1:0] TREE_LO       = 7'h62;
   localparam logic [CHAN_W-1:0] TREE_HI       = 7'h63;
   localparam logic [CHAN_W-1:0] BUILTIN_LO    = 7'h5b;
   localparam logic [CHAN_W-1:0] BUILTIN_HI    = 7'h5e;
endpackage

// ==== testbench/mps_host.sv ====
// Host model: issues one command at a time and waits for its answer.
// Assumes ready and response ports run on the block's clock.
`timescale 1ns/10ps
module mps_host (
   input  wire logic         clock,
   input  wire logic         cmd_ready,
   input  wire logic         rsp_valid,
   output logic              cmd_valid,
   output mps_pkg::mps_cmd_t cmd_code,
   output logic [3:0]        cmd_slot,
   output logic [7:0]        cmd_arg,
   output logic              cmd_arg_neg
);
   import mps_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd_code = CMD_PAIR_Q;
      {cmd_slot, cmd_arg, cmd_arg_neg} = 13'h0;
   end
   // Wait is bounded so a lost answer cannot hang the host
   task automatic send(input mps_cmd_t c, input logic [3:0] s, input logic [7:0] a,
                       input logic n);
      int k;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_slot <= s;
      cmd_arg <= a;
      cmd_arg_neg <= n;
      @(posedge clock);
      while (!cmd_ready) @(posedge clock);
      cmd_valid <= 1'b0;
      k = 0;
      do @(negedge clock); while (!rsp_valid && ++k < 8);
   endtask
endmodule

// ==== testbench/tb_module_pairing_and_scan_list.sv ====
// Bench: table of commands, then paired order and a second reset.
// Assumes the host model and a fixed card population per slot.
`timescale 1ns/10ps
module tb_module_pairing_and_scan_list;
   import mps_pkg::*;
   typedef struct {mps_cmd_t c; logic [3:0] s; logic [7:0] a; logic n, e; logic [15:0] d;} mps_row_t;
   logic clock = 1'b0, sys_rst = 1'b1, setup = 1'b0;
   logic cmd_valid, cmd_ready, cmd_arg_neg, card_op_valid, rsp_valid, rsp_err, op_c2en;
   mps_cmd_t cmd_code, op_code;
   logic [3:0] cmd_slot, card_op_slot;
   logic [7:0] cmd_arg, op_data;
   logic [6:0] op_chan, op_chan2;
   logic [15:0] rsp_data;
   logic [9:0][2:0] kind = {3'h0, 3'h0, 3'h3, 3'h3, 3'h3, 3'h5, 3'h2, 3'h4, 3'h2, 3'h0};
   logic [9:0][2:0] mode = {3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 15'h0};
   logic [3:0] ops[$];
   int errors = 0, checks = 0;
   mps_row_t rows[29] = '{
      '{CMD_PAIR_Q, 4'h1, 8'h0, 1'b0, 1'b0, 16'h0},
      '{CMD_FUNC_Q, 4'h1, 8'h0, 1'b0, 1'b0, 16'h2},
      '{CMD_FUNC_Q, 4'h8, 8'h0, 1'b0, 1'b1, 16'h0},
      '{CMD_BB_READ, 4'h2, 8'h4, 1'b0, 1'b0, 16'h5a},
      '{CMD_BB_READ, 4'h2, 8'h3, 1'b0, 1'b0, 16'hff},
      '{CMD_BB_READ, 4'h4, 8'h4, 1'b0, 1'b1, 16'h0},
      '{CMD_BB_WRITE, 4'h2, 8'h1, 1'b0, 1'b0, 16'h0},
      '{CMD_PAIR, 4'h1, 8'h2, 1'b0, 1'b1, 16'h0},
      '{CMD_PAIR, 4'h5, 8'h6, 1'b0, 1'b1, 16'h0},
      '{CMD_FUNC, 4'h1, 8'h3, 1'b0, 1'b0, 16'h0},
      '{CMD_FUNC, 4'h1, 8'h4, 1'b0, 1'b0, 16'h0},
      '{CMD_FUNC_Q, 4'h1, 8'h0, 1'b0, 1'b0, 16'h4},
      '{CMD_PAIR, 4'h1, 8'h3, 1'b0, 1'b1, 16'h0},
      '{CMD_FUNC, 4'h1, 8'h1, 1'b0, 1'b0, 16'h0},
      '{CMD_FUNC, 4'h3, 8'h1, 1'b0, 1'b0, 16'h0},
      '{CMD_PAIR, 4'h1, 8'h3, 1'b0, 1'b0, 16'h0},
      '{CMD_PAIR, 4'h6, 8'h7, 1'b0, 1'b0, 16'h0},
      '{CMD_PAIR_Q, 4'h1, 8'h0, 1'b0, 1'b0, 16'h1367},
      '{CMD_PAIR, 4'h6, 8'h0, 1'b1, 1'b0, 16'h0},
      '{CMD_PAIR_Q, 4'h1, 8'h0, 1'b0, 1'b0, 16'h1300},
      '{CMD_PAIR, 4'ha, 8'h1, 1'b0, 1'b1, 16'h0},
      '{CMD_SCAN_ADD, 4'h1, 8'h62, 1'b0, 1'b1, 16'h0},
      '{CMD_SCAN_ADD, 4'h0, 8'h5b, 1'b0, 1'b0, 16'h0},
      '{CMD_SCAN_ADD, 4'h0, 8'h5e, 1'b0, 1'b0, 16'h0},
      '{CMD_SCAN_SIZE, 4'h1, 8'h0, 1'b0, 1'b0, 16'h2},
      '{CMD_SCAN_READ, 4'h1, 8'h1, 1'b0, 1'b0, 16'h5e},
      '{CMD_SCAN_READ, 4'h1, 8'h2, 1'b0, 1'b1, 16'h0},
      '{CMD_SCAN_CLEAR, 4'h1, 8'h0, 1'b0, 1'b0, 16'h0},
      '{CMD_SCAN_SIZE, 4'h1, 8'h0, 1'b0, 1'b0, 16'h0}};
   always #12.5 clock = ~clock;
   always @(posedge clock) if (card_op_valid) ops.push_back(card_op_slot);
   mps_host host (.clock(clock), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_slot(cmd_slot), .cmd_arg(cmd_arg),
      .cmd_arg_neg(cmd_arg_neg));
   mps_cmd_top dut (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_slot(cmd_slot), .cmd_arg(cmd_arg),
      .cmd_arg_neg(cmd_arg_neg), .cmd_setup(setup), .cmd_data(8'hc3), .slot_kind(kind),
      .dio_mode(mode), .card_rdata(8'h5a), .card_op_valid(card_op_valid),
      .card_op_code(op_code), .card_op_slot(card_op_slot), .card_op_chan(op_chan),
      .card_op_chan2_en(op_c2en), .card_op_chan2(op_chan2), .card_op_data(op_data),
      .rsp_valid(rsp_valid),
      .rsp_err(rsp_err), .rsp_data(rsp_data));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic run(input mps_row_t r);
      host.send(r.c, r.s, r.a, r.n);
      chk({15'h0, rsp_valid}, 16'h1);
      chk({15'h0, rsp_err}, {15'h0, r.e});
      if (!r.e) chk(rsp_data, r.d);
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clock);
      errors++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      foreach (rows[i]) run(rows[i]);
      ops = {};
      run('{CMD_CLOSE, 4'h3, 8'h05, 1'b0, 1'b0, 16'h0});
      chk(16'(ops.size()), 16'h2);
      chk({12'h0, ops[0]}, 16'h1);
      chk({12'h0, ops[1]}, 16'h3);
      run('{CMD_CLOSE, 4'h3, 8'h06, 1'b0, 1'b1, 16'h0});
      run('{CMD_FUNC, 4'h3, 8'h04, 1'b0, 1'b0, 16'h0});
      run('{CMD_FUNC_Q, 4'h1, 8'h0, 1'b0, 1'b0, 16'h4});
      run('{CMD_CLOSE, 4'h3, 8'h05, 1'b0, 1'b0, 16'h0});
      chk({op_c2en, op_chan2, op_data}, 16'h99c3);
      chk({5'h0, op_code, op_chan}, 16'h0385);
      @(posedge clock) setup <= 1'b1;
      repeat (200) host.send(CMD_SCAN_ADD, 4'h1, 8'h62, 1'b0);
      run('{CMD_SCAN_ADD, 4'h1, 8'h62, 1'b0, 1'b1, 16'h0});
      run('{CMD_SCAN_SIZE, 4'h1, 8'h0, 1'b0, 1'b0, 16'hc8});
      run('{CMD_SCAN_READ, 4'h1, 8'h0, 1'b0, 1'b0, 16'h8e2});
      @(posedge clock) sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      run('{CMD_PAIR_Q, 4'h1, 8'h0, 1'b0, 1'b0, 16'h0});
      run('{CMD_SCAN_SIZE, 4'h1, 8'h0, 1'b0, 1'b0, 16'h0});
      run('{CMD_FUNC_Q, 4'h3, 8'h0, 1'b0, 1'b0, 16'h2});
      finish_test();
   end
endmodule
